// [src/line_unit_config_status_bank.sv]
// per-port configuration and status register bank of the line unit
`timescale 1ns/10ps
//
// Overview of operation
// RULE1: live flags read their current monitored state
// RULE2: latched flags set on change, write one clears
// RULE3: enable bits gate latched flags onto interrupt pin
// RULE4: e3_sel and sonet_sel choose DS3, E3, STS-1
// RULE5: loopback field: none, remote, analog, digital local
// RULE6: soft reset holds port, forces other registers default
// RULE7: device reset clears the soft reset bit
// RULE8: split length field selects 16 to 128 bits
// RULE9: jitter pointers aim for half buffer apart
// RULE10: transmit binary enables encoder, bipolar bypasses it
// RULE11: transmit clock invert picks sampling edge
// RULE12: transmit jitter placement wins over receive placement
// RULE13: transmit powerdown floats the line driver
// RULE14: transmit float is register OR inverted pin
// RULE15: short cable shaping only outside E3 mode
// RULE16: excess zeros at third, or fourth in E3
// RULE17: alternate mode changes E3 violations, drops zeros
// RULE18: receive binary enables decoder and violation pin
// RULE19: receive clock invert picks output alignment edge
// RULE20: receive powerdown floats data, violation, clock outputs
// RULE21: receive float is register OR inverted pin
// RULE22: update rising edge snapshots and clears counter
// RULE23: host writes zeros to reserved bits
// RULE24: interrupt drops when flag or enable clears
// RULE25: interrupt low while any enabled flag set
// RULE26: no jitter enable means both paths bypass
module line_unit_config_status_bank
#(
    parameter int NUM_PORTS = 4
)
(
    input wire logic clock,
    input wire logic rst_b,
    input line_unit_pkg::host_req_t host_req,
    output logic [7:0] host_rdata,
    input wire logic [NUM_PORTS*8-1:0] live_flags_in,
    input wire logic [NUM_PORTS-1:0] tx_hiz_pin_n,
    input wire logic [NUM_PORTS-1:0] rx_hiz_pin_n,
    input wire logic [NUM_PORTS-1:0] cv_event,
    output line_unit_pkg::port_ctrl_t [NUM_PORTS-1:0] port_ctrl,
    output logic irq_out_n
);

    logic [7:0] gcr_r [NUM_PORTS]; // port_global_config
    logic [7:0] tcr_r [NUM_PORTS]; // transmit_config
    logic [7:0] rcr_r [NUM_PORTS]; // receive_config
    logic [15:0] cnt_shot_r [NUM_PORTS]; // host-visible violation count
    logic [7:0] live_now [NUM_PORTS];
    logic [7:0] latched [NUM_PORTS];
    logic [7:0] enable [NUM_PORTS];
    logic [NUM_PORTS-1:0] port_irq;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [1:0] sel_port; // port field of the address
    logic [3:0] sel_reg; // register field of the address

    assign sel_port = host_req.addr[5:4];
    assign sel_reg = host_req.addr[3:0];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORTS; gi++)
        begin : g_port
            logic hit; // access addresses this port
            logic port_rst_b; // low while device or soft reset holds
            logic [7:0] gcr_nxt;
            logic [7:0] tcr_nxt;
            logic [7:0] rcr_nxt;
            logic upd_prev_r; // last seen cv_count_update level
            logic upd_prev_nxt;
            logic [15:0] cnt_r; // running internal violation count
            logic [15:0] cnt_nxt;
            logic [15:0] shot_nxt;
            logic [1:0] hiz_sync_n;
            line_unit_pkg::port_ctrl_t ctrl_r;
            line_unit_pkg::port_ctrl_t ctrl_nxt;
            logic [1:0] ja_len;

            assign hit = (sel_port == 2'(gi));
            assign port_rst_b = rst_b & ~gcr_r[gi][line_unit_pkg::GCR_SOFT_RST];

            // configuration writes, forced defaults under soft reset
            always_comb
            begin
                gcr_nxt = gcr_r[gi];
                tcr_nxt = tcr_r[gi];
                rcr_nxt = rcr_r[gi];
                if (host_req.wr && hit)
                begin
                    if (sel_reg == line_unit_pkg::REG_PORT_CFG)
                    begin
                        // reserved bit is stored as zero whatever is written
                        gcr_nxt = host_req.wdata & line_unit_pkg::GCR_RW_MASK;
                    end
                    else if (sel_reg == line_unit_pkg::REG_TX_CFG)
                    begin
                        tcr_nxt = host_req.wdata;
                    end
                    else if (sel_reg == line_unit_pkg::REG_RX_CFG)
                    begin
                        rcr_nxt = host_req.wdata;
                    end
                end
                if (gcr_r[gi][line_unit_pkg::GCR_SOFT_RST])
                begin
                    // only the reset bit itself stays writable
                    gcr_nxt = line_unit_pkg::GCR_RESET
                            | (gcr_nxt & 8'h01); // RULE6
                    tcr_nxt = line_unit_pkg::TCR_RESET; // RULE6
                    rcr_nxt = line_unit_pkg::RCR_RESET; // RULE6
                end
                if (!rst_b)
                begin
                    gcr_nxt = line_unit_pkg::GCR_RESET; // RULE7
                    tcr_nxt = line_unit_pkg::TCR_RESET;
                    rcr_nxt = line_unit_pkg::RCR_RESET;
                end
            end

            always_ff @(posedge clock)
            begin
                gcr_r[gi] <= gcr_nxt;
                tcr_r[gi] <= tcr_nxt;
                rcr_r[gi] <= rcr_nxt;
            end

            // violation counter with snapshot on update rising edge
            always_comb
            begin
                upd_prev_nxt = rcr_r[gi][line_unit_pkg::RCR_CV_UPDATE];
                cnt_nxt = cnt_r;
                shot_nxt = cnt_shot_r[gi];
                if (cv_event[gi] && cnt_r != line_unit_pkg::CV_COUNT_MAX)
                begin
                    cnt_nxt = cnt_r + 16'h0001; // saturates, never wraps
                end
                if (upd_prev_nxt && !upd_prev_r)
                begin
                    shot_nxt = cnt_r; // RULE22
                    // an event in the update cycle starts the new count
                    cnt_nxt = {15'h0000, cv_event[gi]}; // RULE22
                end
                if (!port_rst_b)
                begin
                    upd_prev_nxt = 1'b0;
                    cnt_nxt = 16'h0000;
                    shot_nxt = 16'h0000;
                end
            end

            always_ff @(posedge clock)
            begin
                upd_prev_r <= upd_prev_nxt;
                cnt_r <= cnt_nxt;
                cnt_shot_r[gi] <= shot_nxt;
            end

            // flags, enables and pin synchronisers of this port
            port_flag_block u_flags
            (
                .clock(clock),
                .port_rst_b(port_rst_b),
                .live_in(live_flags_in[gi*8 +: 8]),
                .hiz_pin_n_in({rx_hiz_pin_n[gi], tx_hiz_pin_n[gi]}),
                .wr_latched(host_req.wr && hit
                            && sel_reg == line_unit_pkg::REG_LATCHED),
                .wr_enable(host_req.wr && hit
                           && sel_reg == line_unit_pkg::REG_ENABLE),
                .wdata(host_req.wdata),
                .live_now(live_now[gi]),
                .hiz_pin_n_sync(hiz_sync_n),
                .latched(latched[gi]),
                .enable(enable[gi]),
                .irq_req(port_irq[gi])
            );

            assign ja_len = {tcr_r[gi][line_unit_pkg::TCR_JA_LEN_HI],
                             tcr_r[gi][line_unit_pkg::TCR_JA_LEN_LO]};

            // decode of the stored fields into line-side controls
            always_comb
            begin
                ctrl_nxt.logic_rst = ~port_rst_b; // RULE6
                if (!gcr_r[gi][line_unit_pkg::GCR_E3_SEL])
                begin
                    ctrl_nxt.rate = line_unit_pkg::RATE_DS3; // RULE4
                end
                else if (gcr_r[gi][line_unit_pkg::GCR_SONET_SEL])
                begin
                    ctrl_nxt.rate = line_unit_pkg::RATE_STS1; // RULE4
                end
                else
                begin
                    ctrl_nxt.rate = line_unit_pkg::RATE_E3; // RULE4
                end
                // in DS3 the sonet bit only picks the alarm pattern
                ctrl_nxt.ais_alt = ~gcr_r[gi][line_unit_pkg::GCR_E3_SEL]
                                 & gcr_r[gi][line_unit_pkg::GCR_SONET_SEL];
                ctrl_nxt.lb_remote = ~gcr_r[gi][line_unit_pkg::GCR_LOCAL_LB]
                                   & gcr_r[gi][line_unit_pkg::GCR_REMOTE_LB];
                ctrl_nxt.lb_analog_local =
                    gcr_r[gi][line_unit_pkg::GCR_LOCAL_LB]
                    & ~gcr_r[gi][line_unit_pkg::GCR_REMOTE_LB]; // RULE5
                ctrl_nxt.lb_digital_local =
                    gcr_r[gi][line_unit_pkg::GCR_LOCAL_LB]
                    & gcr_r[gi][line_unit_pkg::GCR_REMOTE_LB]; // RULE5
                ctrl_nxt.tx_data_sel =
                    {gcr_r[gi][line_unit_pkg::GCR_TX_DSEL_A],
                     gcr_r[gi][line_unit_pkg::GCR_TX_DSEL_B]};
                // transmit placement wins; neither bit means full bypass
                ctrl_nxt.ja_in_tx = tcr_r[gi][line_unit_pkg::TCR_JITTER];
                ctrl_nxt.ja_in_rx = rcr_r[gi][line_unit_pkg::RCR_JITTER]
                    & ~tcr_r[gi][line_unit_pkg::TCR_JITTER]; // RULE12 RULE26
                ctrl_nxt.ja_depth = line_unit_pkg::JA_BASE_DEPTH
                                  << ja_len; // RULE8
                ctrl_nxt.ja_half = 7'(ctrl_nxt.ja_depth >> 1); // RULE9
                ctrl_nxt.tx_binary = tcr_r[gi][line_unit_pkg::TCR_BINARY];
                ctrl_nxt.tx_encode_en =
                    tcr_r[gi][line_unit_pkg::TCR_BINARY]; // RULE10
                ctrl_nxt.tx_sample_fall =
                    tcr_r[gi][line_unit_pkg::TCR_CLK_INV]; // RULE11
                ctrl_nxt.tx_powerdown =
                    tcr_r[gi][line_unit_pkg::TCR_POWERDOWN];
                // driver floats when powered down or tri-stated either way
                ctrl_nxt.tx_float = tcr_r[gi][line_unit_pkg::TCR_POWERDOWN]
                    | tcr_r[gi][line_unit_pkg::TCR_HIZ]
                    | ~hiz_sync_n[0]; // RULE13 RULE14
                ctrl_nxt.tx_short_cable =
                    tcr_r[gi][line_unit_pkg::TCR_SHORT_CABLE]
                    & (ctrl_nxt.rate != line_unit_pkg::RATE_E3); // RULE15
                ctrl_nxt.rx_binary = rcr_r[gi][line_unit_pkg::RCR_BINARY];
                ctrl_nxt.rx_decode_en =
                    rcr_r[gi][line_unit_pkg::RCR_BINARY]; // RULE18
                ctrl_nxt.rx_sample_rise =
                    rcr_r[gi][line_unit_pkg::RCR_CLK_INV]; // RULE19
                ctrl_nxt.rx_powerdown =
                    rcr_r[gi][line_unit_pkg::RCR_POWERDOWN];
                ctrl_nxt.rx_float = rcr_r[gi][line_unit_pkg::RCR_POWERDOWN]
                    | rcr_r[gi][line_unit_pkg::RCR_HIZ]
                    | ~hiz_sync_n[1]; // RULE20 RULE21
                ctrl_nxt.rx_monitor_preamp =
                    rcr_r[gi][line_unit_pkg::RCR_MON_PREAMP];
                ctrl_nxt.exz_limit =
                    (ctrl_nxt.rate == line_unit_pkg::RATE_E3)
                    ? line_unit_pkg::EXZ_LIMIT_E3
                    : line_unit_pkg::EXZ_LIMIT_DS3; // RULE16
                ctrl_nxt.exz_count_en =
                    ~rcr_r[gi][line_unit_pkg::RCR_CV_ALT]; // RULE17
                ctrl_nxt.cv_same_polarity =
                    rcr_r[gi][line_unit_pkg::RCR_CV_ALT]
                    & (ctrl_nxt.rate == line_unit_pkg::RATE_E3); // RULE17
            end

            // controls leave through flops, one cycle behind the fields
            always_ff @(posedge clock)
            begin
                ctrl_r <= ctrl_nxt;
            end

            assign port_ctrl[gi] = ctrl_r;
        end
    endgenerate

    // read mux; absent ports and unmapped offsets return zero
    always_comb
    begin
        rdata_nxt = rdata_r;
        if (!rst_b)
        begin
            rdata_nxt = 8'h00;
        end
        else if (host_req.rd)
        begin
            rdata_nxt = 8'h00;
            if (32'(sel_port) < NUM_PORTS)
            begin
                if (sel_reg == line_unit_pkg::REG_PORT_CFG)
                begin
                    rdata_nxt = gcr_r[sel_port];
                end
                else if (sel_reg == line_unit_pkg::REG_TX_CFG)
                begin
                    rdata_nxt = tcr_r[sel_port];
                end
                else if (sel_reg == line_unit_pkg::REG_RX_CFG)
                begin
                    rdata_nxt = rcr_r[sel_port];
                end
                else if (sel_reg == line_unit_pkg::REG_LIVE)
                begin
                    // no history kept: the synced level right now
                    rdata_nxt = live_now[sel_port]
                              & line_unit_pkg::LIVE_READ_MASK; // RULE1
                end
                else if (sel_reg == line_unit_pkg::REG_LATCHED)
                begin
                    rdata_nxt = latched[sel_port];
                end
                else if (sel_reg == line_unit_pkg::REG_ENABLE)
                begin
                    rdata_nxt = enable[sel_port];
                end
                else if (sel_reg == line_unit_pkg::REG_CNT_LO)
                begin
                    rdata_nxt = cnt_shot_r[sel_port][7:0];
                end
                else if (sel_reg == line_unit_pkg::REG_CNT_HI)
                begin
                    rdata_nxt = cnt_shot_r[sel_port][15:8];
                end
            end
        end
    end

    always_ff @(posedge clock)
    begin
        rdata_r <= rdata_nxt;
    end

    assign host_rdata = rdata_r;
    // open-drain style: low while any port has an enabled latched flag
    assign irq_out_n = ~(|port_irq); // RULE25 RULE3

endmodule : line_unit_config_status_bank

// [include/line_unit_pkg.sv]
// shared offsets, field positions, reset values and carrier types
package line_unit_pkg;

    // register index inside one port's sixteen-byte window
    localparam logic [3:0] REG_PORT_CFG = 4'h0;
    localparam logic [3:0] REG_TX_CFG = 4'h1;
    localparam logic [3:0] REG_RX_CFG = 4'h2;
    localparam logic [3:0] REG_LIVE = 4'h3;
    localparam logic [3:0] REG_LATCHED = 4'h4;
    localparam logic [3:0] REG_ENABLE = 4'h5;
    localparam logic [3:0] REG_CNT_LO = 4'h6;
    localparam logic [3:0] REG_CNT_HI = 4'h7;

    // port_global_config fields
    localparam int GCR_E3_SEL = 7;
    localparam int GCR_SONET_SEL = 6;
    localparam int GCR_LOCAL_LB = 5;
    localparam int GCR_REMOTE_LB = 4;
    localparam int GCR_TX_DSEL_A = 3;
    localparam int GCR_TX_DSEL_B = 2;
    localparam int GCR_SOFT_RST = 0;
    localparam logic [7:0] GCR_RW_MASK = 8'hFD;
    localparam logic [7:0] GCR_RESET = 8'h00;

    // transmit_config fields
    localparam int TCR_JA_LEN_HI = 7;
    localparam int TCR_BINARY = 6;
    localparam int TCR_CLK_INV = 5;
    localparam int TCR_JITTER = 4;
    localparam int TCR_POWERDOWN = 3;
    localparam int TCR_HIZ = 2;
    localparam int TCR_SHORT_CABLE = 1;
    localparam int TCR_JA_LEN_LO = 0;
    localparam logic [7:0] TCR_RESET = 8'h04;

    // receive_config fields
    localparam int RCR_CV_ALT = 7;
    localparam int RCR_BINARY = 6;
    localparam int RCR_CLK_INV = 5;
    localparam int RCR_JITTER = 4;
    localparam int RCR_POWERDOWN = 3;
    localparam int RCR_HIZ = 2;
    localparam int RCR_MON_PREAMP = 1;
    localparam int RCR_CV_UPDATE = 0;
    localparam logic [7:0] RCR_RESET = 8'h04;

    // status bits: jaf, jae, tdm, prbs, pber, rcv, rlol, rlos from 7 to 0
    localparam logic [7:0] LIVE_READ_MASK = 8'h33;
    localparam logic [7:0] FLAG_RISE_MASK = 8'hFF;
    localparam logic [7:0] FLAG_FALL_MASK = 8'h33;
    localparam logic [7:0] LATCHED_RESET = 8'h00;
    localparam logic [7:0] ENABLE_RESET = 8'h00;

    // line rate codes
    localparam logic [1:0] RATE_DS3 = 2'h0;
    localparam logic [1:0] RATE_E3 = 2'h1;
    localparam logic [1:0] RATE_STS1 = 2'h2;

    // jitter buffer depth for the smallest length code, and zero limits
    localparam logic [7:0] JA_BASE_DEPTH = 8'h10;
    localparam logic [2:0] EXZ_LIMIT_DS3 = 3'h3;
    localparam logic [2:0] EXZ_LIMIT_E3 = 3'h4;
    localparam logic [15:0] CV_COUNT_MAX = 16'hFFFF;

    // one host access as seen on the control bus
    typedef struct packed {
        logic rd;
        logic wr;
        logic [5:0] addr;
        logic [7:0] wdata;
    } host_req_t;

    // decoded per-port controls toward the line logic
    typedef struct packed {
        logic logic_rst;
        logic [1:0] rate;
        logic ais_alt;
        logic lb_remote;
        logic lb_analog_local;
        logic lb_digital_local;
        logic [1:0] tx_data_sel;
        logic ja_in_tx;
        logic ja_in_rx;
        logic [7:0] ja_depth;
        logic [6:0] ja_half;
        logic tx_binary;
        logic tx_encode_en;
        logic tx_sample_fall;
        logic tx_powerdown;
        logic tx_float;
        logic tx_short_cable;
        logic rx_binary;
        logic rx_decode_en;
        logic rx_sample_rise;
        logic rx_powerdown;
        logic rx_float;
        logic rx_monitor_preamp;
        logic [2:0] exz_limit;
        logic exz_count_en;
        logic cv_same_polarity;
    } port_ctrl_t;

endpackage : line_unit_pkg

// [src/port_flag_block.sv]
// one port's live, latched and enable flags with input synchronisers
`timescale 1ns/10ps
module port_flag_block
(
    input wire logic clock,
    input wire logic port_rst_b,
    input wire logic [7:0] live_in,
    input wire logic [1:0] hiz_pin_n_in,
    input wire logic wr_latched,
    input wire logic wr_enable,
    input wire logic [7:0] wdata,
    output logic [7:0] live_now,
    output logic [1:0] hiz_pin_n_sync,
    output logic [7:0] latched,
    output logic [7:0] enable,
    output logic irq_req
);

    logic [9:0] meta_r; // first synchroniser stage, read only by sync_r
    logic [9:0] meta_nxt;
    logic [9:0] sync_r; // second stage, safe for logic
    logic [9:0] sync_nxt;
    logic [7:0] prev_r; // last synced live value for edge detection
    logic [7:0] prev_nxt;
    logic [7:0] latched_r;
    logic [7:0] latched_nxt;
    logic [7:0] enable_r;
    logic [7:0] enable_nxt;
    logic [7:0] event_hit;

    // next values of synchronisers, history, latched flags and enables
    always_comb
    begin
        meta_nxt = {hiz_pin_n_in, live_in};
        sync_nxt = meta_r;
        prev_nxt = sync_r[7:0];
        // qualifying change per bit: rising and/or falling as masked
        event_hit = (sync_r[7:0] & ~prev_r & line_unit_pkg::FLAG_RISE_MASK)
                  | (~sync_r[7:0] & prev_r & line_unit_pkg::FLAG_FALL_MASK);
        latched_nxt = latched_r;
        if (wr_latched)
        begin
            latched_nxt = latched_r & ~wdata; // RULE2
        end
        // a change in the clearing cycle is kept: set beats clear
        latched_nxt = latched_nxt | event_hit; // RULE2
        enable_nxt = wr_enable ? wdata : enable_r;
        if (!port_rst_b)
        begin
            latched_nxt = line_unit_pkg::LATCHED_RESET;
            enable_nxt = line_unit_pkg::ENABLE_RESET;
        end
    end

    // register stage; history ignores reset so no false edge at release
    always_ff @(posedge clock)
    begin
        meta_r <= meta_nxt;
        sync_r <= sync_nxt;
        prev_r <= prev_nxt;
        latched_r <= latched_nxt;
        enable_r <= enable_nxt;
    end

    assign live_now = sync_r[7:0]; // RULE1
    assign hiz_pin_n_sync = sync_r[9:8];
    assign latched = latched_r;
    assign enable = enable_r;
    // masked bits never reach the request; drops as soon as either clears
    assign irq_req = |(latched_r & enable_r); // RULE3 RULE24

endmodule : port_flag_block

// [tb/line_unit_checker.sv]
// port-level assertions for the line unit register bank
`timescale 1ns/10ps
module line_unit_checker
#(
    parameter int NUM_PORTS = 4
)
(
    input wire logic clock,
    input wire logic rst_b,
    input line_unit_pkg::host_req_t host_req,
    input wire logic [7:0] host_rdata,
    input wire logic [NUM_PORTS-1:0] tx_hiz_pin_n,
    input line_unit_pkg::port_ctrl_t [NUM_PORTS-1:0] port_ctrl
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    // port zero only; the other ports share the same decode
    line_unit_pkg::port_ctrl_t c0;
    assign c0 = port_ctrl[0];
    // write that sets the soft reset bit of port zero
    sequence soft_wr;
        host_req.wr && host_req.addr == 6'h00 && host_req.wdata[0];
    endsequence
    // pin held low long enough to pass the synchronisers
    sequence pin_low;
        !tx_hiz_pin_n[0] [*4];
    endsequence
    chk_soft_hold: assert property (soft_wr |-> ##2 c0.logic_rst)
        else $error("soft reset not applied");
    chk_pin_float: assert property (pin_low |-> c0.tx_float)
        else $error("transmit pin did not float line");
    chk_ja_prio: assert property (c0.ja_in_tx |-> !c0.ja_in_rx)
        else $error("jitter buffer in both paths");
    chk_ja_half: assert property ({c0.ja_half, 1'b0} == c0.ja_depth)
        else $error("jitter half depth wrong");
    chk_ja_depth: assert property (c0.ja_depth inside {8'h10, 8'h20, 8'h40,
        8'h80})
        else $error("jitter depth not a legal size");
    chk_code_en: assert property (c0.tx_encode_en == c0.tx_binary
        && c0.rx_decode_en == c0.rx_binary)
        else $error("coder enable does not follow binary mode");
    chk_exz_limit: assert property (c0.exz_limit ==
        (c0.rate == line_unit_pkg::RATE_E3 ? 3'h4 : 3'h3))
        else $error("zero limit wrong for rate");
    chk_rdata_hold: assert property (!$past(host_req.rd)
        |-> $stable(host_rdata))
        else $error("read data moved without a read");
endmodule : line_unit_checker

bind line_unit_config_status_bank line_unit_checker #(.NUM_PORTS(NUM_PORTS))
    chk (.clock(clock), .rst_b(rst_b), .host_req(host_req),
    .host_rdata(host_rdata), .tx_hiz_pin_n(tx_hiz_pin_n),
    .port_ctrl(port_ctrl));

// [tb/host_model.sv]
// host processor model on the control bus
`timescale 1ns/10ps
module host_model
(
    input wire logic clock,
    output line_unit_pkg::host_req_t host_req
);
    // idle bus from time zero
    initial host_req = '0;
    // one write, held across one rising edge
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clock);
        host_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(negedge clock);
        host_req = '0;
    endtask : wr
    // one read; the bench watcher picks up the data
    task automatic rd(input logic [5:0] a);
        @(negedge clock);
        host_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(negedge clock);
        host_req = '0;
    endtask : rd
endmodule : host_model

// [tb/tb.sv]
// self-checking bench for the line unit register bank
`timescale 1ns/10ps
module tb;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [31:0] live_flags_in = '0;
    logic [3:0] tx_hiz_pin_n = 4'hF;
    logic [3:0] rx_hiz_pin_n = 4'hF;
    logic [3:0] cv_event = 4'h0;
    line_unit_pkg::host_req_t host_req;
    logic [7:0] host_rdata;
    line_unit_pkg::port_ctrl_t [3:0] port_ctrl;
    line_unit_pkg::port_ctrl_t c;
    logic irq_out_n;
    logic rd_d = 1'b0;
    logic [7:0] exp_q[$];
    logic [7:0] v;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;
    assign c = port_ctrl[0];
    // clock at 40 MHz
    initial forever #12.5 clock = ~clock;
    line_unit_config_status_bank dut (.clock(clock), .rst_b(rst_b),
        .host_req(host_req), .host_rdata(host_rdata),
        .live_flags_in(live_flags_in), .tx_hiz_pin_n(tx_hiz_pin_n),
        .rx_hiz_pin_n(rx_hiz_pin_n), .cv_event(cv_event),
        .port_ctrl(port_ctrl), .irq_out_n(irq_out_n));
    host_model host (.clock(clock), .host_req(host_req));
    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        compares++;
        if (seen !== expd)
        begin
            err_total++;
            $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, expd);
        end
    endtask : check
    task end_sim;
        $display("errors=%0d compares=%0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim
    // note the expectation, then read
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.rd(a);
    endtask : rd
    // write, then let the registered decode land
    task automatic wrc(input logic [5:0] a, input logic [7:0] d);
        host.wr(a, d);
        @(negedge clock);
    endtask : wrc
    // watcher: read data settles half a cycle after the read edge
    always @(posedge clock) rd_d <= host_req.rd;
    always @(negedge clock)
        if (rd_d)
            check(host_rdata, exp_q.pop_front());
    // hang guard
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            err_total++;
            end_sim();
        end
    end
    initial
    begin
        void'($urandom(81));
        repeat (4) @(negedge clock);
        rst_b = 1'b1;
        rd(6'h00, 8'h00);
        rd(6'h01, line_unit_pkg::TCR_RESET);
        rd(6'h02, line_unit_pkg::RCR_RESET);
        rd(6'h08, 8'h00);
        check({c.tx_float, c.rx_float}, 2'b11);
        for (int i = 0; i < 4; i++)
        begin
            v = {i[1:0], i[1:0], 4'h0} | (8'($urandom) & 8'h0C);
            wrc(6'h00, v);
            rd(6'h00, v);
            check(c.rate, i[1] ? (i[0] ? 2'h2 : 2'h1) : 2'h0);
            check(c.ais_alt, i == 1);
            check({c.lb_digital_local, c.lb_analog_local, c.lb_remote},
                i == 0 ? 3'h0 : 3'(1 << (i - 1)));
        end
        wrc(6'h02, 8'h10);
        for (int i = 0; i < 4; i++)
        begin
            v = (8'($urandom) & 8'h7E) | {i[1], 6'h0, i[0]};
            wrc(6'h01, v);
            check(c.ja_depth, 8'h10 << i);
            check({c.ja_in_tx, c.ja_in_rx}, {v[4], !v[4]});
            check({c.tx_encode_en, c.tx_sample_fall, c.tx_powerdown},
                {v[6:5], v[3]});
            check({c.tx_float, c.tx_short_cable},
                {v[3] | v[2], v[1]});
        end
        v = 8'($urandom) & 8'h2A;
        wrc(6'h02, v);
        check({c.rx_sample_rise, c.rx_powerdown, c.rx_float,
            c.rx_monitor_preamp}, {v[5], v[3], v[3], v[1]});
        wrc(6'h01, 8'h00);
        wrc(6'h02, 8'h00);
        check({c.ja_in_tx, c.ja_in_rx, c.tx_float}, 3'h0);
        {rx_hiz_pin_n[0], tx_hiz_pin_n[0]} = 2'b00;
        repeat (4) @(negedge clock);
        check({c.tx_float, c.rx_float}, 2'b11);
        wrc(6'h00, 8'h80);
        wrc(6'h02, 8'hC0);
        check({c.exz_limit, c.exz_count_en, c.cv_same_polarity,
            c.rx_decode_en}, 6'h23);
        live_flags_in[0] = 1'b1;
        repeat (4) @(negedge clock);
        rd(6'h03, 8'h01);
        rd(6'h04, 8'h01);
        check(irq_out_n, 1'b1);
        wrc(6'h05, 8'h01);
        check(irq_out_n, 1'b0);
        wrc(6'h05, 8'h00);
        check(irq_out_n, 1'b1);
        wrc(6'h05, 8'h01);
        wrc(6'h04, 8'h01);
        check(irq_out_n, 1'b1);
        rd(6'h04, 8'h00);
        live_flags_in[0] = 1'b0;
        repeat (4) @(negedge clock);
        rd(6'h04, 8'h01);
        // five counted violations, then two snapshots
        cv_event[0] = 1'b1;
        repeat (5) @(negedge clock);
        cv_event[0] = 1'b0;
        wrc(6'h02, 8'h01);
        rd(6'h06, 8'h05);
        wrc(6'h02, 8'h00);
        wrc(6'h02, 8'h01);
        rd(6'h06, 8'h00);
        rd(6'h07, 8'h00);
        wrc(6'h00, 8'h01);
        wrc(6'h01, 8'h00);
        rd(6'h01, line_unit_pkg::TCR_RESET);
        rd(6'h04, 8'h00);
        rd(6'h00, 8'h01);
        rst_b = 1'b0;
        repeat (2) @(negedge clock);
        rst_b = 1'b1;
        rd(6'h00, 8'h00);
        repeat (3) @(negedge clock);
        end_sim();
    end
endmodule : tb
